// ===== rtl/rpps_top.sv
// Remappable peripheral pin select: APB registers, input and output routing
`timescale 1ns/10ps
module rpps_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Remappable pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_out_en_n,
  // Peripheral outputs, bit k is function code k
  input wire logic [31:0] periph_out_func,
  // Routed peripheral inputs
  output logic ext_irq_one,
  output logic ext_irq_two,
  output logic timer_two_ext_clock,
  output logic timer_three_ext_clock,
  output logic capture_in_one,
  output logic capture_in_two,
  output logic capture_in_seven,
  output logic capture_in_eight,
  output logic compare_fault_a,
  output logic serial_one_receive,
  output logic serial_one_clear_to_send,
  output logic spi_one_data_in,
  output logic spi_one_clock_in,
  output logic spi_one_select_in,
  // Lock state
  output logic remap_write_lock
);

  typedef struct packed {
    rpps_pkg::rpps_phase_t phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic lock;
    logic [rpps_pkg::NUM_IN-1:0][4:0] in_sel;
    logic [rpps_pkg::NUM_PINS-1:0][4:0] out_sel;
    logic [rpps_pkg::NUM_IN-1:0] periph_in;
    logic [rpps_pkg::NUM_PINS-1:0] pin_drive;
    logic [rpps_pkg::NUM_PINS-1:0] pin_off_n;
    logic [rpps_pkg::NUM_PINS-1:0] pin_sample;
  } rpps_state_t;

  rpps_state_t st;
  rpps_state_t next_st;

  logic [rpps_pkg::NUM_IN-1:0] in_routed;
  logic [rpps_pkg::NUM_PINS-1:0] out_routed;
  logic [31:0] pin_src;
  logic [31:0] func_src;

  // Codes past the last pin, all ones among them, see zero
  assign pin_src = {16'h0000, pin_in};
  // Code zero never selects a function
  assign func_src = {periph_out_func[31:1], 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < rpps_pkg::NUM_IN; gi++) begin : g_in
      rpps_sel_mux u_in_mux (
        .sel(st.in_sel[gi]),
        .src(pin_src),
        .dout(in_routed[gi])
      );
    end
    for (gi = 0; gi < rpps_pkg::NUM_PINS; gi++) begin : g_out
      rpps_sel_mux u_out_mux (
        .sel(st.out_sel[gi]),
        .src(func_src),
        .dout(out_routed[gi])
      );
    end
  endgenerate

  // Register read value
  function automatic logic [31:0] read_word(input rpps_state_t s, input logic [11:0] addr);
    logic [31:0] w;
    logic [3:0] ridx;
    logic [2:0] oidx;
    w = 32'h0000_0000;
    ridx = addr[5:2];
    oidx = addr[4:2];
    if (addr >= rpps_pkg::IN_BASE && addr <= rpps_pkg::IN_LAST) begin
      for (int i = 0; i < rpps_pkg::NUM_IN; i++) begin
        if (rpps_pkg::IN_REG_IDX[i] == ridx) begin
          if (rpps_pkg::IN_FIELD_HI[i]) begin
            w[rpps_pkg::HI_LSB +: 5] = s.in_sel[i];
          end else begin
            w[rpps_pkg::LO_LSB +: 5] = s.in_sel[i];
          end
        end
      end
    end else if (addr >= rpps_pkg::OUT_BASE && addr <= rpps_pkg::OUT_LAST) begin
      w[rpps_pkg::LO_LSB +: 5] = s.out_sel[{oidx, 1'b0}];
      w[rpps_pkg::HI_LSB +: 5] = s.out_sel[{oidx, 1'b1}];
    end else if (addr == rpps_pkg::OSC_CTL_ADDR) begin
      w[rpps_pkg::LOCK_BIT] = s.lock;
    end else if (addr == rpps_pkg::PIN_STATUS_ADDR) begin
      w[15:0] = s.pin_sample;
    end else begin
      w = 32'h0000_0000;
    end
    return w;
  endfunction

  // Address decode of the nine input, eight output and two own registers
  function automatic logic is_mapped(input logic [11:0] addr);
    logic ok;
    ok = 1'b0;
    if (addr[1:0] != 2'h0) begin
      ok = 1'b0;
    end else if (addr >= rpps_pkg::IN_BASE && addr <= rpps_pkg::IN_LAST) begin
      ok = 1'b1;
    end else if (addr >= rpps_pkg::OUT_BASE && addr <= rpps_pkg::OUT_LAST) begin
      ok = 1'b1;
    end else if (addr == rpps_pkg::OSC_CTL_ADDR) begin
      ok = 1'b1;
    end else if (addr == rpps_pkg::PIN_STATUS_ADDR) begin
      ok = 1'b1;
    end else begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  always_comb begin
    logic [3:0] ridx;
    logic [2:0] oidx;
    logic wr_ok;
    ridx = paddr[5:2];
    oidx = paddr[4:2];
    wr_ok = 1'b0;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // APB: one wait cycle, then the answer; writes land at the answer edge
    case (st.phase)
      rpps_pkg::RPPS_IDLE: begin
        if (psel && penable) begin
          next_st.phase = rpps_pkg::RPPS_ANSWER;
          next_st.pready = 1'b1;
          next_st.pslverr = ~is_mapped(paddr);
          next_st.prdata = (pwrite || !is_mapped(paddr)) ? 32'h0000_0000 : read_word(st, paddr);
        end
      end
      rpps_pkg::RPPS_ANSWER: begin
        next_st.phase = rpps_pkg::RPPS_IDLE;
        wr_ok = psel && penable && pwrite && is_mapped(paddr);
      end
      default: begin
        next_st.phase = rpps_pkg::RPPS_IDLE;
      end
    endcase

    if (wr_ok) begin
      if (paddr == rpps_pkg::OSC_CTL_ADDR) begin
        next_st.lock = pwdata[rpps_pkg::LOCK_BIT];
      end else if (st.lock) begin
        // Routing stays as it was while locked
        next_st.in_sel = st.in_sel;
      end else if (paddr <= rpps_pkg::IN_LAST) begin
        for (int i = 0; i < rpps_pkg::NUM_IN; i++) begin
          if (rpps_pkg::IN_REG_IDX[i] == ridx) begin
            if (rpps_pkg::IN_FIELD_HI[i]) begin
              next_st.in_sel[i] = pwdata[rpps_pkg::HI_LSB +: 5];
            end else begin
              next_st.in_sel[i] = pwdata[rpps_pkg::LO_LSB +: 5];
            end
          end
        end
      end else if (paddr >= rpps_pkg::OUT_BASE && paddr <= rpps_pkg::OUT_LAST) begin
        next_st.out_sel[{oidx, 1'b0}] = pwdata[rpps_pkg::LO_LSB +: 5];
        next_st.out_sel[{oidx, 1'b1}] = pwdata[rpps_pkg::HI_LSB +: 5];
      end
    end

    // Input routing, one cycle behind the pins
    next_st.periph_in = in_routed;

    // Output routing per pin
    for (int p = 0; p < rpps_pkg::NUM_PINS; p++) begin
      if (st.out_sel[p] == rpps_pkg::OUT_SEL_NULL) begin
        next_st.pin_drive[p] = 1'b0;
        next_st.pin_off_n[p] = 1'b1;
      end else begin
        next_st.pin_drive[p] = out_routed[p];
        next_st.pin_off_n[p] = 1'b0;
      end
    end

    next_st.pin_sample = pin_in;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st.phase <= rpps_pkg::RPPS_IDLE;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.prdata <= 32'h0000_0000;
      st.lock <= rpps_pkg::LOCK_RESET;
      for (int i = 0; i < rpps_pkg::NUM_IN; i++) begin
        st.in_sel[i] <= rpps_pkg::IN_SEL_RESET;
      end
      for (int p = 0; p < rpps_pkg::NUM_PINS; p++) begin
        st.out_sel[p] <= rpps_pkg::OUT_SEL_RESET;
      end
      st.periph_in <= 14'h0000;
      st.pin_drive <= 16'h0000;
      st.pin_off_n <= 16'hffff;
      st.pin_sample <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pin_out = st.pin_drive;
  assign pin_out_en_n = st.pin_off_n;
  assign remap_write_lock = st.lock;
  assign ext_irq_one = st.periph_in[rpps_pkg::IN_EXT_IRQ_ONE];
  assign ext_irq_two = st.periph_in[rpps_pkg::IN_EXT_IRQ_TWO];
  assign timer_two_ext_clock = st.periph_in[rpps_pkg::IN_TIMER_TWO_CLK];
  assign timer_three_ext_clock = st.periph_in[rpps_pkg::IN_TIMER_THREE_CLK];
  assign capture_in_one = st.periph_in[rpps_pkg::IN_CAPTURE_ONE];
  assign capture_in_two = st.periph_in[rpps_pkg::IN_CAPTURE_TWO];
  assign capture_in_seven = st.periph_in[rpps_pkg::IN_CAPTURE_SEVEN];
  assign capture_in_eight = st.periph_in[rpps_pkg::IN_CAPTURE_EIGHT];
  assign compare_fault_a = st.periph_in[rpps_pkg::IN_COMPARE_FAULT_A];
  assign serial_one_receive = st.periph_in[rpps_pkg::IN_SERIAL_RX];
  assign serial_one_clear_to_send = st.periph_in[rpps_pkg::IN_SERIAL_CTS];
  assign spi_one_data_in = st.periph_in[rpps_pkg::IN_SPI_DATA];
  assign spi_one_clock_in = st.periph_in[rpps_pkg::IN_SPI_CLOCK];
  assign spi_one_select_in = st.periph_in[rpps_pkg::IN_SPI_SELECT];

endmodule

// ===== common/rpps_pkg.sv
// Constants, register map and field layout of the remappable pin select block
package rpps_pkg;

  // Sizes
  localparam int NUM_PINS = 16;
  localparam int NUM_IN = 14;
  localparam int NUM_IN_REGS = 9;
  localparam int NUM_OUT_REGS = 8;
  localparam int SEL_W = 5;
  localparam int ADDR_W = 12;
  localparam int NUM_FUNC = 32;

  // Register byte addresses
  localparam logic [11:0] IN_BASE = 12'h000;
  localparam logic [11:0] IN_LAST = 12'h020;
  localparam logic [11:0] OUT_BASE = 12'h040;
  localparam logic [11:0] OUT_LAST = 12'h05c;
  localparam logic [11:0] OSC_CTL_ADDR = 12'h080;
  localparam logic [11:0] PIN_STATUS_ADDR = 12'h084;

  // Field positions
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;
  localparam int LOCK_BIT = 6;

  // Values after reset and special codes
  localparam logic [4:0] IN_SEL_RESET = 5'h1f;
  localparam logic [4:0] OUT_SEL_RESET = 5'h00;
  localparam logic [4:0] OUT_SEL_NULL = 5'h00;
  localparam logic LOCK_RESET = 1'b0;

  // Peripheral input indices
  localparam int IN_EXT_IRQ_ONE = 0;
  localparam int IN_EXT_IRQ_TWO = 1;
  localparam int IN_TIMER_TWO_CLK = 2;
  localparam int IN_TIMER_THREE_CLK = 3;
  localparam int IN_CAPTURE_ONE = 4;
  localparam int IN_CAPTURE_TWO = 5;
  localparam int IN_CAPTURE_SEVEN = 6;
  localparam int IN_CAPTURE_EIGHT = 7;
  localparam int IN_COMPARE_FAULT_A = 8;
  localparam int IN_SERIAL_RX = 9;
  localparam int IN_SERIAL_CTS = 10;
  localparam int IN_SPI_DATA = 11;
  localparam int IN_SPI_CLOCK = 12;
  localparam int IN_SPI_SELECT = 13;

  // Input register index of each peripheral input, highest input first
  localparam logic [NUM_IN-1:0][3:0] IN_REG_IDX = {
    4'h8, 4'h7, 4'h7, 4'h6, 4'h6, 4'h5, 4'h4, 4'h4, 4'h3, 4'h3, 4'h2, 4'h2, 4'h1, 4'h0
  };
  // Set where the input's field sits in bits 12-8, clear for bits 4-0
  localparam logic [NUM_IN-1:0] IN_FIELD_HI = 14'h14a9;

  typedef enum logic {
    RPPS_IDLE,
    RPPS_ANSWER
  } rpps_phase_t;

endpackage

// ===== rtl/rpps_sel_mux.sv
// One-of-32 selector used for both input and output routing
`timescale 1ns/10ps
module rpps_sel_mux (
  // Selection
  input wire logic [4:0] sel,
  // Candidate sources
  input wire logic [31:0] src,
  // Selected source
  output logic dout
);

  always_comb begin
    dout = src[sel];
  end

endmodule

// ===== test/rpps_checker.sv
// Port assertions for the pin select block
`timescale 1ns/10ps
module rpps_checker (
  // Bus
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and lock
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_out_en_n,
  input wire logic remap_write_lock
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_rd;
    pready && !pwrite && !pslverr;
  endsequence
  property p_rdy;
    s_acc |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no answer");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err;
    (s_acc and (paddr[1:0] != 2'h0)) |=> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unaligned taken");
  property p_errd;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_errd: assert property (p_errd) else $error("bad error reply");
  property p_null;
    (pin_out & pin_out_en_n) == 16'h0;
  endproperty
  a_null: assert property (p_null) else $error("idle pin driven");
  property p_lock;
    !$stable(remap_write_lock) |-> $past(pready && psel && pwrite && paddr == 12'h080);
  endproperty
  a_lock: assert property (p_lock) else $error("lock moved");
  property p_lockrd;
    (s_rd and (paddr == 12'h080)) |-> prdata == {25'h0, remap_write_lock, 6'h0};
  endproperty
  a_lockrd: assert property (p_lockrd) else $error("lock read");
  property p_fld;
    (s_rd and (paddr <= 12'h05c)) |-> prdata[31:13] == 19'h0 && prdata[7:5] == 3'h0;
  endproperty
  a_fld: assert property (p_fld) else $error("unused bits set");
endmodule

// ===== test/rpps_far_model.sv
// Far side model: pins and peripheral outputs
`timescale 1ns/10ps
module rpps_far_model (
  // Bench control
  input wire logic [15:0] pin_level,
  input wire logic [31:0] func_level,
  // Block side
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_out_en_n,
  output logic [15:0] pin_in,
  output logic [31:0] periph_out_func,
  output logic [15:0] pin_wire
);
  // Pin follows the block where enabled, outside drive elsewhere
  assign pin_wire = (pin_out & ~pin_out_en_n) | (pin_level & pin_out_en_n);
  assign pin_in = pin_wire;
  assign periph_out_func = func_level;
endmodule

// ===== test/remappable_peripheral_pin_select_test.sv
// Self-checking bench for the pin select block
`timescale 1ns/10ps
module remappable_peripheral_pin_select_test;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, lock, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, func_level, periph_out_func, rd;
  logic [15:0] pin_in, pin_out, pin_out_en_n, pin_level, pin_wire;
  logic [13:0] ins;
  int fail_count = 0, n_tests = 0, cycles = 0;
  rpps_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_out_en_n(pin_out_en_n), .periph_out_func(periph_out_func), .ext_irq_one(ins[0]), .ext_irq_two(ins[1]),
    .timer_two_ext_clock(ins[2]), .timer_three_ext_clock(ins[3]), .capture_in_one(ins[4]),
    .capture_in_two(ins[5]), .capture_in_seven(ins[6]), .capture_in_eight(ins[7]), .compare_fault_a(ins[8]),
    .serial_one_receive(ins[9]), .serial_one_clear_to_send(ins[10]), .spi_one_data_in(ins[11]),
    .spi_one_clock_in(ins[12]), .spi_one_select_in(ins[13]), .remap_write_lock(lock));
  rpps_far_model far_u (.pin_level(pin_level), .func_level(func_level), .pin_out(pin_out),
    .pin_out_en_n(pin_out_en_n), .pin_in(pin_in), .periph_out_func(periph_out_func), .pin_wire(pin_wire));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1);
    chk(32'(k), 32'h2);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_reset;
    chk({pin_out_en_n, 2'h0, ins}, 32'hffff0000);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h00001f00);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0000001f);
    apb(1'b0, 12'h05c, 32'h0);
    chk({rd[30:0], err}, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h002, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic t_inputs;
    logic [4:0] p;
    for (int i = 0; i < 14; i++) begin
      p = 5'((i * 7) % 16);
      apb(1'b1, {6'h0, rpps_pkg::IN_REG_IDX[i], 2'h0},
        rpps_pkg::IN_FIELD_HI[i] ? {19'h0, p, 8'h1f} : {19'h0, 5'h1f, 3'h0, p});
      pin_level <= 16'h1 << p;
      repeat (3) @(posedge ref_clk);
      chk({31'h0, ins[i]}, 32'h1);
      pin_level <= ~(16'h1 << p);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, ins[i]}, 32'h0);
    end
    pin_level <= 16'hffff;
    apb(1'b1, 12'h000, 32'h00001000);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, ins[0]}, 32'h0);
    apb(1'b1, 12'h000, 32'hffffffff);
    apb(1'b0, 12'h000, 32'h0);
    chk({rd[31:1], ins[0]}, 32'h00001f00);
  endtask
  task automatic t_outputs;
    logic [4:0] c;
    pin_level <= 16'h0;
    for (int j = 0; j < 16; j++) begin
      c = 5'(2 * j + 1);
      apb(1'b1, 12'(64 + 4 * (j / 2)), (j % 2) ? {19'h0, c, 8'h0} : {27'h0, c});
      func_level <= 32'h1 << c;
      repeat (3) @(posedge ref_clk);
      chk({30'h0, pin_wire[j], pin_out_en_n[j]}, 32'h2);
      func_level <= ~(32'h1 << c);
      repeat (3) @(posedge ref_clk);
      chk({30'h0, pin_wire[j], pin_out_en_n[j]}, 32'h0);
    end
    func_level <= 32'hffffffff;
    apb(1'b1, 12'h040, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk({30'h0, pin_wire[0], pin_out_en_n[0]}, 32'h1);
  endtask
  task automatic t_lock;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h080, 32'h00000040);
    apb(1'b0, 12'h080, 32'h0);
    chk({rd[31:1], lock}, 32'h00000041);
    apb(1'b1, 12'h000, 32'h00000300);
    apb(1'b0, 12'h000, 32'h0);
    pin_level <= 16'h0001;
    repeat (3) @(posedge ref_clk);
    chk({rd[31:1], ins[0]}, 32'h1);
    apb(1'b1, 12'h040, 32'h0000001f);
    apb(1'b0, 12'h040, 32'h0);
    chk({rd[30:0], pin_out_en_n[0]}, 32'h1);
    apb(1'b1, 12'h080, 32'h0);
    apb(1'b1, 12'h000, 32'h00000300);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h00000300);
  endtask
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin_level = 16'h0;
    func_level = 32'h0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_inputs;
    t_outputs;
    t_lock;
    give_verdict;
  end
endmodule
bind rpps_top rpps_checker chk_u (.ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
  .pin_out_en_n(pin_out_en_n), .remap_write_lock(remap_write_lock));
